// File: verilog/fault_pkg.sv
// Shared constants, types and alarm classification for the fault policy block
package fault_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL       = 8'h00;
	localparam logic [7:0] OFF_DELAY      = 8'h04;
	localparam logic [7:0] OFF_STATE      = 8'h08;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h14;
	localparam logic [7:0] OFF_ALARM      = 8'h18;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		POL_NORMAL       = 2'b00,
		POL_TRIP_RESET_A = 2'b01,
		POL_TRIP_RESET_B = 2'b10,
		POL_BYPASS       = 2'b11
	} policy_t;

	// Bits [6:4] out_sel, [3] bus_coast_en, [2] act_high, [1:0] policy
	typedef struct packed {
		logic [2:0] out_sel;
		logic       bus_coast_en;
		logic       act_high;
		policy_t    policy;
	} ctrl_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic trip;
		logic lock;
		logic em_trip;
		logic bypass;
	} alarm_class_t;

	// ------------------------------------------------------------
	// Reset values and widths
	// ------------------------------------------------------------
	localparam int          CTRL_W     = 7;
	localparam int          DELAY_W    = 16;
	localparam int          ALARM_W    = 7;
	localparam int          IRQ_W      = 5;
	localparam logic [6:0]  CTRL_RST   = 7'h04;
	localparam logic [15:0] DELAY_RST  = 16'h03E8;
	localparam logic [6:0]  ALARM_NONE = 7'h00;

	// Interrupt status bit positions
	localparam int IRQ_TRIP       = 0;
	localparam int IRQ_LOCK       = 1;
	localparam int IRQ_BYPASS     = 2;
	localparam int IRQ_WARN       = 3;
	localparam int IRQ_WAS_ACTIVE = 4;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          TICK_TIME_NS  = 1000000;
	localparam int          TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
	localparam logic [7:0]  FLASH_HALF_MS = 8'hFA;
	localparam int          OUT_COUNT     = 4;

	// ------------------------------------------------------------
	// Alarm codes
	// ------------------------------------------------------------
	localparam logic [6:0] AL_LIVE_ZERO      = 7'h02;
	localparam logic [6:0] AL_MAINS_IMBAL    = 7'h04;
	localparam logic [6:0] AL_OVERVOLT       = 7'h07;
	localparam logic [6:0] AL_UNDERVOLT      = 7'h08;
	localparam logic [6:0] AL_INV_OVERLOAD   = 7'h09;
	localparam logic [6:0] AL_MOT_OVERLOAD   = 7'h0A;
	localparam logic [6:0] AL_MOT_THERMISTOR = 7'h0B;
	localparam logic [6:0] AL_CURR_LIMIT     = 7'h0C;
	localparam logic [6:0] AL_OVERCURRENT    = 7'h0D;
	localparam logic [6:0] AL_GROUND_LEAK    = 7'h0E;
	localparam logic [6:0] AL_AUX_SUPPLY     = 7'h0F;
	localparam logic [6:0] AL_OUTPUT_SHORT   = 7'h10;
	localparam logic [6:0] AL_SERIAL_TIMEOUT = 7'h11;
	localparam logic [6:0] AL_FAST_TIMEOUT   = 7'h12;
	localparam logic [6:0] AL_AUTOTUNE       = 7'h16;
	localparam logic [6:0] AL_HEATSINK       = 7'h1D;
	localparam logic [6:0] AL_PHASE_U        = 7'h1E;
	localparam logic [6:0] AL_PHASE_V        = 7'h1F;
	localparam logic [6:0] AL_PHASE_W        = 7'h20;
	localparam logic [6:0] AL_FAST_COMM      = 7'h22;
	localparam logic [6:0] AL_GATE           = 7'h25;
	localparam logic [6:0] AL_SAFETY_STOP    = 7'h3C;
	localparam logic [6:0] AL_LOW_CURRENT    = 7'h3F;
	localparam logic [6:0] AL_WAS_ACTIVE     = 7'h50;
	localparam logic [6:0] AL_UNKNOWN        = 7'h63;

	// Trip, lock, emergency trip-and-reset, bypass per alarm code
	function automatic alarm_class_t classify(input logic [6:0] code);
		alarm_class_t c;
		unique case (code)
			AL_OVERCURRENT, AL_GROUND_LEAK, AL_AUX_SUPPLY, AL_OUTPUT_SHORT, AL_GATE:
				c = '{trip: 1'b1, lock: 1'b1, em_trip: 1'b1, bypass: 1'b1};
			AL_MAINS_IMBAL, AL_HEATSINK:
				c = '{trip: 1'b1, lock: 1'b1, em_trip: 1'b0, bypass: 1'b1};
			AL_LIVE_ZERO, AL_OVERVOLT, AL_UNDERVOLT, AL_INV_OVERLOAD, AL_MOT_OVERLOAD,
			AL_MOT_THERMISTOR, AL_CURR_LIMIT, AL_SERIAL_TIMEOUT, AL_FAST_TIMEOUT,
			AL_AUTOTUNE, AL_PHASE_U, AL_PHASE_V, AL_PHASE_W, AL_FAST_COMM,
			AL_SAFETY_STOP, AL_LOW_CURRENT, AL_WAS_ACTIVE:
				c = '{trip: 1'b1, lock: 1'b0, em_trip: 1'b0, bypass: 1'b0};
			default:
				c = '{trip: 1'b1, lock: 1'b1, em_trip: 1'b0, bypass: 1'b0};
		endcase
		return c;
	endfunction : classify

endpackage : fault_pkg

// File: verilog/bypass_delay.sv
// Millisecond tick divider and programmable bypass delay counter
`timescale 1ns/100ps
module bypass_delay #(
	parameter int TICK_CYCLES = fault_pkg::TICK_CYCLES
) (
	input  wire logic                         clock,
	input  wire logic                         rstn,
	input  wire logic                         start,
	input  wire logic                         clear,
	input  wire logic [fault_pkg::DELAY_W-1:0] delay_ms,
	output logic                              tick_q,
	output logic                              done_q
);

	logic [31:0]                       div_q,  div_d;
	logic                              tick_d;
	logic                              run_q,  run_d;
	logic                              done_d;
	logic [fault_pkg::DELAY_W-1:0]     cnt_q,  cnt_d;

	always_comb begin
		tick_d = (div_q == 32'(TICK_CYCLES - 1));
		div_d  = tick_d ? 32'h0000_0000 : div_q + 32'h0000_0001;
		run_d  = run_q;
		cnt_d  = cnt_q;
		done_d = done_q;
		if (clear) begin
			run_d  = 1'b0;
			done_d = 1'b0;
		end else if (start && !run_q && !done_q) begin
			run_d = 1'b1;
			cnt_d = delay_ms;
		end else if (run_q && (cnt_q == '0)) begin
			run_d  = 1'b0;
			done_d = 1'b1;
		end else if (run_q && tick_q) begin
			cnt_d = cnt_q - 16'h0001;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			div_q  <= 32'h0000_0000;
			tick_q <= 1'b0;
			run_q  <= 1'b0;
			done_q <= 1'b0;
			cnt_q  <= 16'h0000;
		end else begin
			div_q  <= div_d;
			tick_q <= tick_d;
			run_q  <= run_d;
			done_q <= done_d;
			cnt_q  <= cnt_d;
		end
	end

endmodule : bypass_delay

// File: verilog/emergency_run_fault_policy.sv
// Fault trip/lock policy with emergency-run, auto reset and delayed bypass output
`timescale 1ns/100ps

module emergency_run_fault_policy #(
	parameter int TICK_CYCLES = fault_pkg::TICK_CYCLES
) (
	input  wire logic                         clock,
	input  wire logic                         rstn,
	input  wire fault_pkg::bus_req_t          bus,
	output logic [31:0]                       rdata_q,
	input  wire logic                         alarm_valid,
	input  wire logic [fault_pkg::ALARM_W-1:0] alarm_code,
	input  wire logic                         reset_cmd,
	input  wire logic                         bus_coast,
	input  wire logic                         limit_exceeded,
	input  wire logic                         emergency_pin,
	input  wire logic                         coast_inhibit_pin,
	input  wire logic                         relay_fitted_pin,
	input  wire logic                         service_mem_pin,
	output logic                              trip_q,
	output logic                              lock_q,
	output logic [fault_pkg::ALARM_W-1:0]     active_alarm_q,
	output logic                              coast_q,
	output logic                              em_active_q,
	output logic [fault_pkg::OUT_COUNT-1:0]   digital_out_q,
	output logic [fault_pkg::OUT_COUNT-1:0]   relay_out_q,
	output logic                              warn_flash_q,
	output logic                              service_mem_q,
	output logic                              irq_q
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Bit 0 emergency, 1 coast inhibit, 2 relay fitted, 3 service memory
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
		end else begin
			sync1_q <= {service_mem_pin, relay_fitted_pin, coast_inhibit_pin, emergency_pin};
			sync2_q <= sync1_q;
		end
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	fault_pkg::ctrl_t                 ctrl_q,   ctrl_d;
	logic [fault_pkg::DELAY_W-1:0]    delay_q,  delay_d;
	logic [fault_pkg::IRQ_W-1:0]      irq_st_q, irq_st_d;
	logic [fault_pkg::IRQ_W-1:0]      irq_en_q, irq_en_d;
	logic [31:0]                      rdata_d;
	logic                             irq_d;
	logic                             trip_d,   lock_d;
	logic [fault_pkg::ALARM_W-1:0]    active_alarm_d;
	logic                             coast_d,  em_active_d;
	logic [fault_pkg::OUT_COUNT-1:0]  digital_out_d, relay_out_d;
	logic                             warn_flash_d;
	logic                             bypass_q, bypass_d;
	logic                             warn_q,   warn_d;
	logic                             pend_q,   pend_d;
	logic [7:0]                       flash_q,  flash_d;

	// Combinational helpers
	fault_pkg::alarm_class_t          cls;
	logic [fault_pkg::ALARM_W-1:0]    code_eff;
	logic                             take;
	logic                             activated;
	logic                             em_fall;
	logic                             trip_reset_mode;
	logic                             start_delay;
	logic                             clear_delay;
	logic                             delay_done;
	logic                             tick;
	logic [fault_pkg::IRQ_W-1:0]      irq_ev;
	logic [fault_pkg::OUT_COUNT-1:0]  onehot;

	// ------------------------------------------------------------
	// Bypass delay
	// ------------------------------------------------------------
	bypass_delay #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_delay (
		.clock    (clock),
		.rstn     (rstn),
		.start    (start_delay),
		.clear    (clear_delay),
		.delay_ms (delay_q),
		.tick_q   (tick),
		.done_q   (delay_done)
	);

	// ------------------------------------------------------------
	// Policy next state
	// ------------------------------------------------------------
	always_comb begin
		// Coast from the bus counts only when the bus is allowed as a source
		coast_d   = !sync2_q[1] || (ctrl_q.bus_coast_en && bus_coast);
		activated = ctrl_q.act_high ? sync2_q[0] : !sync2_q[0];
		em_active_d = (ctrl_q.policy != fault_pkg::POL_NORMAL) && activated && !coast_d;
		em_fall   = em_active_q && !em_active_d;
		trip_reset_mode = (ctrl_q.policy == fault_pkg::POL_TRIP_RESET_A)
			|| (ctrl_q.policy == fault_pkg::POL_TRIP_RESET_B);

		// An external alarm has priority; the was-active alarm waits until no external alarm is valid
		take     = alarm_valid || pend_q;
		code_eff = alarm_valid ? alarm_code : fault_pkg::AL_WAS_ACTIVE;
		pend_d   = (pend_q && alarm_valid) || em_fall;
		cls      = fault_pkg::classify(code_eff);

		trip_d         = trip_q;
		lock_d         = lock_q;
		active_alarm_d = active_alarm_q;
		start_delay    = 1'b0;

		// Clears first so that a new alarm in the same cycle wins
		if (reset_cmd && !lock_q) begin
			trip_d         = 1'b0;
			active_alarm_d = fault_pkg::ALARM_NONE;
		end
		if (em_active_q && trip_reset_mode && trip_q) begin
			trip_d         = 1'b0;
			active_alarm_d = fault_pkg::ALARM_NONE;
		end

		if (take) begin
			if (!em_active_q) begin
				trip_d         = trip_d || cls.trip;
				lock_d         = lock_q || cls.lock;
				active_alarm_d = code_eff;
			end else if (ctrl_q.policy == fault_pkg::POL_BYPASS) begin
				if (cls.bypass) begin
					trip_d         = 1'b1;
					active_alarm_d = code_eff;
					start_delay    = 1'b1;
				end
			end else if (cls.em_trip) begin
				trip_d         = 1'b1;
				active_alarm_d = code_eff;
			end
		end

		// Bypass holds until the emergency ends or a manual reset is given while not locked
		clear_delay = !em_active_q || (reset_cmd && !lock_q);
		bypass_d    = !clear_delay && (bypass_q || delay_done);

		// Bypass routing: selections 0-3 digital, 4-7 relay if fitted
		onehot        = 4'h1 << ctrl_q.out_sel[1:0];
		digital_out_d = (bypass_d && !ctrl_q.out_sel[2]) ? onehot : 4'h0;
		relay_out_d   = (bypass_d && ctrl_q.out_sel[2] && sync2_q[2]) ? onehot : 4'h0;

		// Service flag comes back from non-volatile storage after power-up
		warn_d = warn_q || (em_active_q && limit_exceeded) || sync2_q[3];
		flash_d      = flash_q;
		warn_flash_d = warn_flash_q;
		if (!warn_q) begin
			flash_d      = 8'h00;
			warn_flash_d = 1'b0;
		end else if (tick) begin
			if (flash_q == fault_pkg::FLASH_HALF_MS - 8'h01) begin
				flash_d      = 8'h00;
				warn_flash_d = !warn_flash_q;
			end else begin
				flash_d = flash_q + 8'h01;
			end
		end else if (!warn_flash_q && (flash_q == 8'h00)) begin
			warn_flash_d = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Register bus and interrupts
	// ------------------------------------------------------------
	always_comb begin
		ctrl_d   = ctrl_q;
		delay_d  = delay_q;
		irq_en_d = irq_en_q;
		irq_ev   = '0;
		irq_ev[fault_pkg::IRQ_TRIP]       = trip_d && !trip_q;
		irq_ev[fault_pkg::IRQ_LOCK]       = lock_d && !lock_q;
		irq_ev[fault_pkg::IRQ_BYPASS]     = bypass_d && !bypass_q;
		irq_ev[fault_pkg::IRQ_WARN]       = warn_d && !warn_q;
		irq_ev[fault_pkg::IRQ_WAS_ACTIVE] = em_fall;
		irq_st_d = irq_st_q;
		if (bus.wr) begin
			unique case (bus.addr)
				fault_pkg::OFF_CTRL:       ctrl_d   = bus.wdata[fault_pkg::CTRL_W-1:0];
				fault_pkg::OFF_DELAY:      delay_d  = bus.wdata[fault_pkg::DELAY_W-1:0];
				fault_pkg::OFF_IRQ_ENABLE: irq_en_d = bus.wdata[fault_pkg::IRQ_W-1:0];
				fault_pkg::OFF_IRQ_CLEAR:  irq_st_d = irq_st_q & ~bus.wdata[fault_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
		// New events win over a clear in the same cycle
		irq_st_d = irq_st_d | irq_ev;
		irq_d    = |(irq_st_q & irq_en_q);

		rdata_d = 32'h0000_0000;
		if (bus.rd) begin
			unique case (bus.addr)
				fault_pkg::OFF_CTRL:       rdata_d = {25'h000_0000, ctrl_q};
				fault_pkg::OFF_DELAY:      rdata_d = {16'h0000, delay_q};
				fault_pkg::OFF_STATE:      rdata_d = {26'h000_0000, bypass_q, warn_q,
					em_active_q, coast_q, lock_q, trip_q};
				fault_pkg::OFF_IRQ_STATUS: rdata_d = {27'h000_0000, irq_st_q};
				fault_pkg::OFF_IRQ_ENABLE: rdata_d = {27'h000_0000, irq_en_q};
				fault_pkg::OFF_ALARM:      rdata_d = {25'h000_0000, active_alarm_q};
				default:                   rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrl_q         <= fault_pkg::CTRL_RST;
			delay_q        <= fault_pkg::DELAY_RST;
			irq_st_q       <= '0;
			irq_en_q       <= '0;
			rdata_q        <= 32'h0000_0000;
			irq_q          <= 1'b0;
			trip_q         <= 1'b0;
			lock_q         <= 1'b0;
			active_alarm_q <= fault_pkg::ALARM_NONE;
			coast_q        <= 1'b0;
			em_active_q    <= 1'b0;
			digital_out_q  <= 4'h0;
			relay_out_q    <= 4'h0;
			warn_flash_q   <= 1'b0;
			service_mem_q  <= 1'b0;
			bypass_q       <= 1'b0;
			warn_q         <= 1'b0;
			pend_q         <= 1'b0;
			flash_q        <= 8'h00;
		end else begin
			ctrl_q         <= ctrl_d;
			delay_q        <= delay_d;
			irq_st_q       <= irq_st_d;
			irq_en_q       <= irq_en_d;
			rdata_q        <= rdata_d;
			irq_q          <= irq_d;
			trip_q         <= trip_d;
			lock_q         <= lock_d;
			active_alarm_q <= active_alarm_d;
			coast_q        <= coast_d;
			em_active_q    <= em_active_d;
			digital_out_q  <= digital_out_d;
			relay_out_q    <= relay_out_d;
			warn_flash_q   <= warn_flash_d;
			service_mem_q  <= warn_d;
			bypass_q       <= bypass_d;
			warn_q         <= warn_d;
			pend_q         <= pend_d;
			flash_q        <= flash_d;
		end
	end

endmodule : emergency_run_fault_policy

// File: dv/drive_io_model.sv
// Model of the drive terminals and fieldbus master facing the fault policy block
`timescale 1ns/100ps
module drive_io_model (
	input  wire logic clock,
	input  wire logic em_want,
	input  wire logic active_high,
	input  wire logic coast_force,
	input  wire logic relay_fit,
	input  wire logic svc_want,
	output logic      emergency_pin,
	output logic      coast_inhibit_pin,
	output logic      bus_coast,
	output logic      relay_fitted_pin,
	output logic      service_mem_pin
);
	initial {emergency_pin, coast_inhibit_pin, bus_coast, relay_fitted_pin, service_mem_pin} = 5'h08;
	// Coast is only sent when the bench orders it, to show the bus path counts only when bus_coast_en is set
	always @(posedge clock) begin
		emergency_pin     <= em_want ~^ active_high;
		coast_inhibit_pin <= 1'b1;
		bus_coast         <= coast_force;
		relay_fitted_pin  <= relay_fit;
		service_mem_pin   <= svc_want;
	end
endmodule : drive_io_model

// File: dv/emergency_run_fault_policy_monitor.sv
// Port-level checks of the fault policy block
`timescale 1ns/100ps
module emergency_run_fault_policy_monitor #(
	parameter int TICK_CYCLES = fault_pkg::TICK_CYCLES
) (
	input wire logic                            clock,
	input wire logic                            rstn,
	input wire logic                            alarm_valid,
	input wire logic [fault_pkg::ALARM_W-1:0]   alarm_code,
	input wire logic                            reset_cmd,
	input wire logic                            trip_q,
	input wire logic                            lock_q,
	input wire logic [fault_pkg::ALARM_W-1:0]   active_alarm_q,
	input wire logic                            em_active_q,
	input wire logic [fault_pkg::OUT_COUNT-1:0] digital_out_q,
	input wire logic [fault_pkg::OUT_COUNT-1:0] relay_out_q
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	// ------------------------------------------------------------
	// Trip and lock
	// ------------------------------------------------------------
	lock_hold_a: assert property (lock_q |=> lock_q)
		else $error("lock released while powered");
	em_nolock_a: assert property (em_active_q && alarm_valid && !lock_q |=> !lock_q)
		else $error("lock latched in emergency run");
	normal_lock_a: assert property (!em_active_q && alarm_valid && alarm_code inside
		{7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h25, 7'h04, 7'h1D} |=> trip_q && lock_q)
		else $error("lock-class alarm did not trip and lock");
	normal_nolock_a: assert property (!em_active_q && alarm_valid && !lock_q && alarm_code == 7'h02
		|=> trip_q && !lock_q && active_alarm_q == 7'h02)
		else $error("plain alarm not reported as trip without lock");
	unknown_lock_a: assert property (!em_active_q && alarm_valid && alarm_code == 7'h63
		|=> trip_q && lock_q && active_alarm_q == 7'h63)
		else $error("unknown fault did not trip and lock");
	em_ignore_a: assert property (em_active_q && alarm_valid && !trip_q
		&& alarm_code inside {7'h02, 7'h63} |=> !trip_q)
		else $error("ignored alarm tripped in emergency run");
	manual_reset_a: assert property (!em_active_q && trip_q && !lock_q && reset_cmd && !alarm_valid
		|=> !trip_q)
		else $error("manual reset did not clear trip");
	// ------------------------------------------------------------
	// Bypass output
	// ------------------------------------------------------------
	bypass_onehot_a: assert property ($onehot0({digital_out_q, relay_out_q}))
		else $error("bypass on more than one output");
	bypass_cause_a: assert property ($rose(|{digital_out_q, relay_out_q}) |-> $past(em_active_q))
		else $error("bypass raised outside emergency run");
	bypass_drop_a: assert property (!em_active_q [*3] |-> !(|{digital_out_q, relay_out_q}))
		else $error("bypass kept after emergency run ended");
endmodule : emergency_run_fault_policy_monitor

bind emergency_run_fault_policy emergency_run_fault_policy_monitor #(
	.TICK_CYCLES(TICK_CYCLES)
) monitor (
	.clock, .rstn, .alarm_valid, .alarm_code, .reset_cmd, .trip_q, .lock_q,
	.active_alarm_q, .em_active_q, .digital_out_q, .relay_out_q
);

// File: dv/emergency_run_fault_policy_bench.sv
// Self-checking bench for the emergency-run fault policy block
`timescale 1ns/100ps
module emergency_run_fault_policy_bench;
	localparam int TICKS = 10;
	logic                clock, rstn, alarm_valid, reset_cmd, limit_exceeded;
	logic                em_want, active_high, coast_force, relay_fit, coast_q;
	logic                trip_q, lock_q, em_active_q, warn_flash_q, service_mem_q, irq_q;
	logic                emergency_pin, coast_inhibit_pin, bus_coast, relay_fitted_pin;
	logic                service_mem_pin, svc_want;
	logic [6:0]          alarm_code, active_alarm_q;
	logic [3:0]          digital_out_q, relay_out_q;
	logic [31:0]         rdata_q, rv, lfsr;
	fault_pkg::bus_req_t bus;
	int                  err_total, compares, cycles, n;
	int                  sel[2] = '{1, 6};
	int known[$] = '{2, 4, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 22, 29, 30, 31, 32,
		34, 37, 60, 63, 80, 99};
	int locks[$] = '{4, 13, 14, 15, 16, 29, 37, 99};
	int em_trip[$] = '{13, 14, 15, 16, 37};

	emergency_run_fault_policy #(.TICK_CYCLES(TICKS)) uut (
		.clock, .rstn, .bus, .rdata_q, .alarm_valid, .alarm_code, .reset_cmd, .bus_coast,
		.limit_exceeded, .emergency_pin, .coast_inhibit_pin, .relay_fitted_pin, .service_mem_pin,
		.trip_q, .lock_q, .active_alarm_q, .coast_q, .em_active_q, .digital_out_q, .relay_out_q,
		.warn_flash_q, .service_mem_q, .irq_q
	);
	drive_io_model io (
		.clock, .em_want, .active_high, .coast_force, .relay_fit, .emergency_pin,
		.svc_want, .coast_inhibit_pin, .bus_coast, .relay_fitted_pin, .service_mem_pin
	);

	// ------------------------------------------------------------
	// Reference model and bus tasks
	// ------------------------------------------------------------
	function automatic bit in_list(input int code, input int list[$]);
		foreach (list[k]) if (list[k] == code) return 1'b1;
		return 1'b0;
	endfunction : in_list
	// Codes outside the known set behave as unknown faults
	function automatic bit exp_lock(input int code);
		return in_list(code, locks) || !in_list(code, known);
	endfunction : exp_lock
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("Counts: %0d compares, %0d mismatches", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		bus <= '0;
		@(posedge clock);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
		@(posedge clock);
		bus <= '0;
		#1 d = rdata_q;
		@(posedge clock);
	endtask : rd
	task automatic raise(input int code);
		alarm_valid <= 1'b1;
		alarm_code  <= 7'(code);
		@(posedge clock);
		alarm_valid <= 1'b0;
		#1;
	endtask : raise
	task automatic do_reset();
		rstn <= 1'b0;
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		repeat (4) @(posedge clock);
	endtask : do_reset
	// Pins cross two synchronisers, so five edges cover the whole path
	task automatic set_em(input logic [6:0] ctrl, input logic want, input logic cf, input logic ex);
		wr(fault_pkg::OFF_CTRL, 32'(ctrl));
		em_want     <= want;
		active_high <= ctrl[2];
		coast_force <= cf;
		repeat (5) @(posedge clock);
		#1 check(32'(em_active_q), 32'(ex));
	endtask : set_em
	task automatic normal_case(input int code);
		do_reset();
		raise(code);
		check(32'(trip_q), 32'h1);
		check(32'(lock_q), 32'(exp_lock(code)));
		check(32'(active_alarm_q), 32'(code));
		reset_cmd <= 1'b1;
		@(posedge clock);
		reset_cmd <= 1'b0;
		@(posedge clock);
		#1 check(32'(trip_q), 32'(exp_lock(code)));
	endtask : normal_case

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			conclude();
		end
	end

	initial begin
		{rstn, alarm_valid, reset_cmd, limit_exceeded, em_want, coast_force} = '0;
		{active_high, relay_fit} = 2'h3;
		svc_want = 1'b0;
		alarm_code = '0;
		bus = '0;
		lfsr = 32'h0000_0f41;
		do_reset();
		rd(fault_pkg::OFF_CTRL, rv);
		check(rv, 32'h0000_0004);
		rd(fault_pkg::OFF_DELAY, rv);
		check(rv, 32'h0000_03E8);
		lfsr = lfsr_next(lfsr);
		wr(fault_pkg::OFF_DELAY, {16'h0000, lfsr[15:0]});
		rd(fault_pkg::OFF_DELAY, rv);
		check(rv, {16'h0000, lfsr[15:0]});
		rd(8'h1C, rv);
		check(rv, 32'h0000_0000);
		$display("registers done");
		foreach (known[k]) normal_case(known[k]);
		repeat (4) begin
			lfsr = lfsr_next(lfsr);
			normal_case(int'({1'b1, lfsr[5:0]}));
		end
		$display("normal mode done");
		for (int p = 1; p <= 2; p++) begin
			do_reset();
			set_em(7'(4 + p), 1'b1, 1'b0, 1'b1);
			foreach (known[k]) begin
				raise(known[k]);
				check(32'(trip_q), 32'(in_list(known[k], em_trip)));
				@(posedge clock);
				#1 check(32'(trip_q), 32'h0);
				check(32'(lock_q), 32'h0);
			end
		end
		$display("trip and reset done");
		do_reset();
		set_em(7'h04, 1'b1, 1'b0, 1'b0);
		set_em(7'h01, 1'b1, 1'b0, 1'b1);
		set_em(7'h01, 1'b0, 1'b0, 1'b0);
		set_em(7'h0D, 1'b1, 1'b1, 1'b0);
		check(32'(coast_q), 32'h1);
		set_em(7'h05, 1'b1, 1'b1, 1'b1);
		check(32'(coast_q), 32'h0);
		coast_force <= 1'b0;
		$display("activation done");
		foreach (sel[k]) begin
			do_reset();
			wr(fault_pkg::OFF_DELAY, 32'h0000_0003);
			set_em(7'(sel[k] * 16 + 7), 1'b1, 1'b0, 1'b1);
			raise(29);
			check(32'(trip_q), 32'h1);
			repeat (15) @(posedge clock);
			#1 check(32'({digital_out_q, relay_out_q}), 32'h0);
			for (n = 0; n < 40 && {digital_out_q, relay_out_q} == 8'h00; n++) @(posedge clock);
			#1 check(32'({digital_out_q, relay_out_q}),
				sel[k] < 4 ? 32'h10 << sel[k] : 32'h1 << (sel[k] - 4));
		end
		em_want <= 1'b0;
		repeat (8) @(posedge clock);
		#1 check(32'({digital_out_q, relay_out_q}), 32'h0);
		check(32'(active_alarm_q), 32'h0000_0050);
		check(32'(lock_q), 32'h0);
		rd(fault_pkg::OFF_IRQ_STATUS, rv);
		check(rv, 32'h0000_0015);
		check(32'(irq_q), 32'h0);
		wr(fault_pkg::OFF_IRQ_ENABLE, 32'h0000_0010);
		#1 check(32'(irq_q), 32'h1);
		wr(fault_pkg::OFF_IRQ_CLEAR, 32'h0000_0010);
		#1 check(32'(irq_q), 32'h0);
		rd(fault_pkg::OFF_IRQ_STATUS, rv);
		check(rv, 32'h0000_0005);
		$display("bypass and interrupts done");
		do_reset();
		set_em(7'h05, 1'b1, 1'b0, 1'b1);
		limit_exceeded <= 1'b1;
		@(posedge clock);
		limit_exceeded <= 1'b0;
		for (n = 0; n < 3000 && warn_flash_q !== 1'b1; n++) @(posedge clock);
		for (n = 0; n < 3000 && warn_flash_q !== 1'b0; n++) @(posedge clock);
		#1 check(32'(n < 3000), 32'h1);
		check(32'(service_mem_q), 32'h1);
		rd(fault_pkg::OFF_STATE, rv);
		check(rv, 32'h0000_0018);
		// Stored service flag read back at power-up must bring the warning back
		svc_want <= 1'b1;
		do_reset();
		#1 check(32'(service_mem_q), 32'h1);
		svc_want <= 1'b0;
		$display("warning done");
		conclude();
	end
endmodule : emergency_run_fault_policy_bench
